//--- pkg/urs_pkg.sv
// Register map, field positions, reset values and timing constants of the serial receiver
package urs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  localparam logic [11:0] ADDR_MODE    = 12'h220;
  localparam logic [11:0] ADDR_STATUS  = 12'h222;
  localparam logic [11:0] ADDR_TXDATA  = 12'h224;
  localparam logic [11:0] ADDR_RXDATA  = 12'h226;
  localparam logic [11:0] ADDR_BAUD    = 12'h228;
  localparam logic [11:0] ADDR_INTSTAT = 12'h22a;
  localparam logic [11:0] ADDR_INTMASK = 12'h22c;

  localparam logic [15:0] MODE_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0110;
  localparam logic [15:0] RXDATA_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET   = 16'h0000;

  // Mode fields
  localparam int MODE_ENABLE_BIT = 15;
  localparam int MODE_FMT_HI     = 2;
  localparam int MODE_FMT_LO     = 1;
  localparam logic [15:0] MODE_WMASK = 16'h8006;

  // Data and parity selection codes
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;

  // Status and control fields
  localparam int STAT_SREMPTY_BIT = 8;
  localparam int STAT_RXLVL_HI    = 7;
  localparam int STAT_RXLVL_LO    = 6;
  localparam int STAT_ADDRDET_BIT = 5;
  localparam int STAT_IDLE_BIT    = 4;
  localparam int STAT_PARERR_BIT  = 3;
  localparam int STAT_FRMERR_BIT  = 2;
  localparam int STAT_OVR_BIT     = 1;
  localparam int STAT_AVAIL_BIT   = 0;
  localparam logic [1:0] RXLVL_3_4  = 2'h2;
  localparam logic [1:0] RXLVL_FULL = 2'h3;

  // Interrupt event bits
  localparam int INT_W       = 4;
  localparam int INT_RX_BIT  = 0;
  localparam int INT_OVR_BIT = 1;
  localparam int INT_FRM_BIT = 2;
  localparam int INT_PAR_BIT = 3;

  // Character and buffer layout
  localparam int CHAR_W     = 9;
  localparam int ENTRY_W    = CHAR_W + 2;
  localparam int FIFO_DEPTH = 4;

  // Oversampling of each bit period
  localparam int OVERSAMPLE = 16;
  localparam int MID_SAMPLE = OVERSAMPLE / 2;
endpackage

//--- pkg/urs_fifo_if.sv
// Connection between the receiver core and its character buffer
`timescale 1ns/1ps
`default_nettype none
interface urs_fifo_if #(
  parameter int W     = 11,
  parameter int DEPTH = 4
);
  logic                         push;
  logic [W-1:0]                 push_data;
  logic                         pop;
  logic                         flush;
  logic [W-1:0]                 head;
  logic [$clog2(DEPTH+1)-1:0]   count;
  logic                         full;
  logic                         empty;

  modport owner (output push, push_data, pop, flush, input head, count, full, empty);
  modport store (input push, push_data, pop, flush, output head, count, full, empty);
endinterface
`default_nettype wire

//--- src/urs_sync.sv
// Two-flop synchroniser for the receive line
`timescale 1ns/1ps
`default_nettype none
module urs_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  // Resets to the idle line level so no false start bit appears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- src/urs_fifo.sv
// Receive character buffer held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module urs_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  urs_fifo_if.store q
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic          do_push;
  logic          do_pop;

  assign do_push = q.push && !q.full;
  assign do_pop  = q.pop && !q.empty;
  assign q.full  = (q.count == CW'(DEPTH));
  assign q.empty = (q.count == '0);
  assign q.head  = mem[rd_ptr];

  // Storage is not reset; count and pointers decide what is valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr  <= '0;
      wr_ptr  <= '0;
      q.count <= '0;
    end else if (q.flush) begin
      rd_ptr  <= '0;
      wr_ptr  <= '0;
      q.count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (do_pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      if (do_push && !do_pop) begin
        q.count <= CW'(q.count + 1'b1);
      end else if (do_pop && !do_push) begin
        q.count <= CW'(q.count - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

//--- src/urs_top.sv
// Serial port receive path: line receiver, status flags, register file and interrupt
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RL1) Status bit 4 reads 1 while receiver idle, 0 while receiving a character.
// (RL2) Status bit 3 shows parity error of the character at buffer head.
// (RL3) Status bit 2 shows framing error of the character at buffer head.
// (RL4) Status bit 1 set on buffer overflow; software may read or clear only.
// (RL5) Clearing a set overrun flag empties the buffer and the shift register.
// (RL6) Status bit 0 is 1 when a character can be read, 0 when empty.
// (RL7) Reset loads status 0x0110; mode, receive data and divisor load zero.
// (RL8) Transmit data register content is undefined after reset.
// (RL9) Unimplemented register bits read zero and ignore writes.
// (RL10) Receive buffer holds four characters and is full with four waiting.
// (RL11) Character arriving at a full buffer sets overrun and is discarded.
module urs_top #(
  parameter int DEPTH = urs_pkg::FIFO_DEPTH
) (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        RX_PIN,
  input  wire logic [11:0] ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             IRQ,
  output logic      [8:0]  TX_DATA,
  output logic             TX_LOAD
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int EW = urs_pkg::ENTRY_W;
  localparam int NW = urs_pkg::CHAR_W;

  typedef enum logic [2:0] {
    URS_IDLE,
    URS_START,
    URS_DATA,
    URS_PARITY,
    URS_STOP
  } urs_state_t;

  urs_fifo_if #(.W(EW), .DEPTH(DEPTH)) fq ();

  urs_state_t                 state;
  logic                       rx_line;
  logic [15:0]                serial_mode_control;
  logic [15:0]                baud_divisor;
  logic [1:0]                 rx_int_select;
  logic                       address_detect;
  logic                       overrun_flag;
  logic [urs_pkg::INT_W-1:0]  int_status;
  logic [urs_pkg::INT_W-1:0]  int_mask;
  logic [urs_pkg::INT_W-1:0]  int_event;
  logic [15:0]                baud_cnt;
  logic                       tick;
  logic [3:0]                 os_cnt;
  logic [3:0]                 bit_idx;
  logic [NW-1:0]              receive_shift_register;
  logic                       parity_bit;
  logic                       done;
  logic [NW-1:0]              done_data;
  logic                       done_frm_err;
  logic                       done_par_err;
  logic                       parity_bad;
  logic [15:0]                rx_data_word;
  logic                       accept;
  logic                       overrun_set;
  logic                       overrun_clear;
  logic                       flush;
  logic                       port_enable;
  logic [1:0]                 frame_format;
  logic                       nine_bit;
  logic                       parity_on;
  logic                       last_os;
  logic [3:0]                 last_bit;
  logic                       receiver_idle_flag;
  logic                       parity_error_flag;
  logic                       framing_error_flag;
  logic                       rx_data_available_flag;
  logic [15:0]                status_value;
  logic [15:0]                next_rdata;
  logic                       wr_status;

  // The line passes two flops before the receiver looks at it
  urs_sync u_sync (
    .clk  (MCLK),
    .rst  (RESET),
    .din  (RX_PIN),
    .dout (rx_line)
  );

  urs_fifo #(.W(EW), .DEPTH(DEPTH)) u_fifo (
    .clk (MCLK),
    .rst (RESET),
    .q   (fq.store)
  );

  assign port_enable = serial_mode_control[urs_pkg::MODE_ENABLE_BIT];
  // Frame format decode; every code but the nine-bit one carries eight data bits
  assign frame_format = serial_mode_control[urs_pkg::MODE_FMT_HI:urs_pkg::MODE_FMT_LO];
  assign nine_bit    = (frame_format == urs_pkg::FMT_9N);
  assign parity_on   = (frame_format == urs_pkg::FMT_8E) || (frame_format == urs_pkg::FMT_8O);
  assign last_bit    = nine_bit ? 4'(NW - 1) : 4'(NW - 2);
  assign last_os     = (os_cnt == 4'(urs_pkg::OVERSAMPLE - 1));
  assign wr_status   = WR && (ADDR == urs_pkg::ADDR_STATUS);

  // Bit-rate tick: the divisor plus one system clocks per oversample
  // At or above, so lowering the divisor mid-count cannot stall the port for a counter wrap
  assign tick = port_enable && (baud_cnt >= baud_divisor);

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      baud_cnt <= '0;
    end else if (tick || !port_enable) begin
      baud_cnt <= '0;
    end else begin
      baud_cnt <= 16'(baud_cnt + 1'b1);
    end
  end

  // Line receiver; start bit is rechecked at its middle to reject glitches
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state                  <= URS_IDLE;
      os_cnt                 <= '0;
      bit_idx                <= '0;
      receive_shift_register <= '0;
      parity_bit             <= 1'b0;
      done                   <= 1'b0;
      done_data              <= '0;
      done_frm_err           <= 1'b0;
      done_par_err           <= 1'b0;
    end else begin
      done <= 1'b0;
      if (flush || !port_enable) begin
        state                  <= URS_IDLE; // RL5
        receive_shift_register <= '0; // RL5
        os_cnt                 <= '0;
      end else begin
        unique case (state)
          URS_IDLE: begin
            if (!rx_line) begin
              state  <= URS_START;
              os_cnt <= '0;
            end
          end
          URS_START: begin
            if (tick) begin
              if (os_cnt == 4'(urs_pkg::MID_SAMPLE - 1)) begin
                os_cnt                 <= '0;
                bit_idx                <= '0;
                receive_shift_register <= '0;
                state                  <= rx_line ? URS_IDLE : URS_DATA;
              end else begin
                os_cnt <= 4'(os_cnt + 1'b1);
              end
            end
          end
          URS_DATA: begin
            if (tick) begin
              os_cnt <= 4'(os_cnt + 1'b1);
              if (last_os) begin
                receive_shift_register[bit_idx] <= rx_line;
                bit_idx                         <= 4'(bit_idx + 1'b1);
                if (bit_idx == last_bit) begin
                  state <= parity_on ? URS_PARITY : URS_STOP;
                end
              end
            end
          end
          URS_PARITY: begin
            if (tick) begin
              os_cnt <= 4'(os_cnt + 1'b1);
              if (last_os) begin
                parity_bit <= rx_line;
                state      <= URS_STOP;
              end
            end
          end
          URS_STOP: begin
            if (tick) begin
              os_cnt <= 4'(os_cnt + 1'b1);
              if (last_os) begin
                state        <= URS_IDLE;
                done         <= 1'b1;
                done_data    <= receive_shift_register;
                done_frm_err <= !rx_line;
                done_par_err <= parity_bad;
              end
            end
          end
        endcase
      end
    end
  end

  assign receiver_idle_flag = (state == URS_IDLE); // RL1

  // Odd format wants an odd count of ones over data and parity bit, even format an even one
  assign parity_bad = parity_on
                      && ((^{receive_shift_register[NW-2:0], parity_bit})
                          != (frame_format == urs_pkg::FMT_8O));

  // In address-detect mode with the nine-bit format only characters with the top bit set are kept
  assign accept = done && !overrun_flag // RL11
                  && !(address_detect && nine_bit && !done_data[NW-1]);
  assign overrun_set   = accept && fq.full; // RL10
  assign fq.push       = accept && !fq.full; // RL11
  assign fq.push_data  = {done_par_err, done_frm_err, done_data};
  assign fq.pop        = RD && (ADDR == urs_pkg::ADDR_RXDATA);
  // Only a real one-to-zero change flushes; a new overrun in that cycle wins
  assign overrun_clear = wr_status && overrun_flag && !WDATA[urs_pkg::STAT_OVR_BIT];
  assign flush         = overrun_clear && !overrun_set; // RL5
  assign fq.flush      = flush;

  // Only hardware sets the flag; a software write of one to it is ignored
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      overrun_flag <= 1'b0;
    end else if (overrun_set) begin
      overrun_flag <= 1'b1; // RL4
    end else if (overrun_clear) begin
      overrun_flag <= 1'b0; // RL4
    end
  end

  // Error flags follow the head character, so each data read advances them
  assign rx_data_available_flag = !fq.empty; // RL6
  assign parity_error_flag      = !fq.empty && fq.head[EW-1]; // RL2
  assign framing_error_flag     = !fq.empty && fq.head[EW-2]; // RL3

  // Control registers
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      serial_mode_control <= urs_pkg::MODE_RESET; // RL7
      baud_divisor        <= urs_pkg::BAUD_RESET; // RL7
      rx_int_select       <= urs_pkg::STATUS_RESET[urs_pkg::STAT_RXLVL_HI:urs_pkg::STAT_RXLVL_LO];
      address_detect      <= urs_pkg::STATUS_RESET[urs_pkg::STAT_ADDRDET_BIT];
      int_mask            <= '0;
    end else if (WR) begin
      unique case (ADDR)
        urs_pkg::ADDR_MODE: begin
          serial_mode_control <= WDATA & urs_pkg::MODE_WMASK; // RL9
        end
        urs_pkg::ADDR_BAUD: begin
          baud_divisor <= WDATA;
        end
        urs_pkg::ADDR_STATUS: begin
          rx_int_select  <= WDATA[urs_pkg::STAT_RXLVL_HI:urs_pkg::STAT_RXLVL_LO];
          address_detect <= WDATA[urs_pkg::STAT_ADDRDET_BIT];
        end
        urs_pkg::ADDR_INTMASK: begin
          int_mask <= WDATA[urs_pkg::INT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Holding register toward the transmitter; deliberately left without reset
  always_ff @(posedge MCLK) begin
    if (WR && (ADDR == urs_pkg::ADDR_TXDATA)) begin
      TX_DATA <= WDATA[NW-1:0]; // RL8
    end
  end

  // One-cycle strobe telling the transmitter that a new character waits
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      TX_LOAD <= 1'b0;
    end else begin
      TX_LOAD <= WR && (ADDR == urs_pkg::ADDR_TXDATA);
    end
  end

  // Receive event honours the fill-level selection before the push
  always_comb begin
    int_event                       = '0;
    int_event[urs_pkg::INT_OVR_BIT] = overrun_set;
    int_event[urs_pkg::INT_FRM_BIT] = fq.push && done_frm_err;
    int_event[urs_pkg::INT_PAR_BIT] = fq.push && done_par_err;
    unique case (rx_int_select)
      urs_pkg::RXLVL_FULL: int_event[urs_pkg::INT_RX_BIT] = fq.push
                                                             && (fq.count == CW'(DEPTH - 1));
      urs_pkg::RXLVL_3_4:  int_event[urs_pkg::INT_RX_BIT] = fq.push
                                                             && (fq.count == CW'(DEPTH - 2));
      default:              int_event[urs_pkg::INT_RX_BIT] = fq.push;
    endcase
  end

  // Sticky events, cleared by writing one; a new event beats a clear
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      int_status <= '0;
    end else if (WR && (ADDR == urs_pkg::ADDR_INTSTAT)) begin
      int_status <= int_event | (int_status & ~WDATA[urs_pkg::INT_W-1:0]);
    end else begin
      int_status <= int_event | int_status;
    end
  end

  assign IRQ = |(int_status & int_mask);

  // Status word; transmitter fields outside this block read as zero, empty flag as one
  always_comb begin
    status_value                             = '0; // RL9
    status_value[urs_pkg::STAT_SREMPTY_BIT] = urs_pkg::STATUS_RESET[urs_pkg::STAT_SREMPTY_BIT];
    status_value[urs_pkg::STAT_RXLVL_HI:urs_pkg::STAT_RXLVL_LO] = rx_int_select;
    status_value[urs_pkg::STAT_ADDRDET_BIT]  = address_detect;
    status_value[urs_pkg::STAT_IDLE_BIT]     = receiver_idle_flag; // RL1
    status_value[urs_pkg::STAT_PARERR_BIT]   = parity_error_flag; // RL2
    status_value[urs_pkg::STAT_FRMERR_BIT]   = framing_error_flag; // RL3
    status_value[urs_pkg::STAT_OVR_BIT]      = overrun_flag; // RL4
    status_value[urs_pkg::STAT_AVAIL_BIT]    = rx_data_available_flag; // RL6
  end

  // An empty buffer reads as the zero reset value
  assign rx_data_word = fq.empty ? urs_pkg::RXDATA_RESET : 16'(fq.head[NW-1:0]); // RL9

  always_comb begin
    next_rdata = '0;
    unique case (ADDR)
      urs_pkg::ADDR_MODE:    next_rdata = serial_mode_control;
      urs_pkg::ADDR_STATUS:  next_rdata = status_value;
      urs_pkg::ADDR_RXDATA:  next_rdata = rx_data_word;
      urs_pkg::ADDR_BAUD:    next_rdata = baud_divisor;
      urs_pkg::ADDR_INTSTAT: next_rdata = 16'(int_status);
      urs_pkg::ADDR_INTMASK: next_rdata = 16'(int_mask);
      default:               next_rdata = '0;
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? next_rdata : '0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/urs_monitor.sv
// Port-level assertions of the serial receiver register interface
`timescale 1ns/1ps
`default_nettype none
module urs_monitor (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic [11:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic [8:0]  TX_DATA,
  input wire logic        TX_LOAD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic st_rd;
  logic known;
  assign st_rd = RD && ADDR == urs_pkg::ADDR_STATUS;
  assign known = ADDR inside {urs_pkg::ADDR_MODE, urs_pkg::ADDR_STATUS, urs_pkg::ADDR_TXDATA,
    urs_pkg::ADDR_RXDATA, urs_pkg::ADDR_BAUD, urs_pkg::ADDR_INTSTAT, urs_pkg::ADDR_INTMASK};
  property p_idle_bus; !$past(RD) |-> RDATA == 16'h0000; endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("read data outside read slot");
  property p_unmapped; RD && !known |=> RDATA == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tx_read; RD && ADDR == urs_pkg::ADDR_TXDATA |=> RDATA == 16'h0000; endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit data readable");
  property p_stat_fixed; st_rd |=> RDATA[15:8] == 8'h01; endproperty
  a_stat_fixed: assert property (p_stat_fixed) else $error("status upper bits wrong");
  property p_rx_upper;
    RD && ADDR == urs_pkg::ADDR_RXDATA |=> RDATA[15:9] == 7'h00;
  endproperty
  a_rx_upper: assert property (p_rx_upper) else $error("receive data upper bits set");
  property p_mode_bits;
    RD && ADDR == urs_pkg::ADDR_MODE |=> (RDATA & ~urs_pkg::MODE_WMASK) == 16'h0000;
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode unused bits set");
  // Error flags describe the head character, so an empty buffer shows none
  property p_err_empty; st_rd ##1 !RDATA[0] |-> RDATA[3:2] == 2'h0; endproperty
  a_err_empty: assert property (p_err_empty) else $error("error flag with empty buffer");
  property p_txload; TX_LOAD == $past(WR && ADDR == urs_pkg::ADDR_TXDATA); endproperty
  a_txload: assert property (p_txload) else $error("transmit load pulse wrong");
  property p_txdata; TX_LOAD |-> TX_DATA == $past(WDATA[8:0]); endproperty
  a_txdata: assert property (p_txdata) else $error("transmit data not as written");
  c_avail: cover property (st_rd ##1 RDATA[0]);
  c_overrun: cover property (st_rd ##1 RDATA[1]);
  c_txload: cover property (TX_LOAD);
endmodule
bind urs_top urs_monitor u_mon (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .TX_DATA(TX_DATA), .TX_LOAD(TX_LOAD));
`default_nettype wire

//--- testbench/urs_line_model.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module urs_line_model #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  output var logic  line
);
  initial line = 1'b1;
  task automatic send_bit(input logic b);
    line <= b;
    repeat (BIT) @(posedge clk);
  endtask
  // Stop level is selectable so that a broken frame can be sent on purpose
  task automatic send(input logic [8:0] d, input int n, input logic par_on,
                      input logic par, input logic stop);
    @(posedge clk);
    send_bit(1'b0);
    for (int i = 0; i < n; i++) begin
      send_bit(d[i]);
    end
    if (par_on) begin
      send_bit(par);
    end
    send_bit(stop);
    // One idle bit so a low stop is not mistaken for the next start
    send_bit(1'b1);
  endtask
endmodule
`default_nettype wire

//--- testbench/urs_top_tb.sv
// Register-level test of the serial receiver status path
`timescale 1ns/1ps
`default_nettype none
module urs_top_tb;
  logic        mclk;
  logic        reset;
  wire logic   rx_pin;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        irq;
  logic [8:0]  tx_data;
  logic        tx_load;
  int          fails;
  int          checked;

  urs_top uut (.MCLK(mclk), .RESET(reset), .RX_PIN(rx_pin), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .TX_DATA(tx_data), .TX_LOAD(tx_load));
  urs_line_model #(.BIT(16)) lm (.clk(mclk), .line(rx_pin));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  // Baud divisor 0 gives 16 clocks a bit; the pause lets the push land
  task automatic snd(input logic [8:0] d, input logic pon, input logic par, input logic stp);
    lm.send(d, 8, pon, par, stp);
    repeat (4) @(posedge mclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    results();
  end

  initial begin
    reset = 1'b1;
    addr  = 12'h000;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
    fails = 0;
    checked = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rchk(urs_pkg::ADDR_MODE, 16'h0000);
    rchk(urs_pkg::ADDR_STATUS, 16'h0110);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0000);
    rchk(urs_pkg::ADDR_BAUD, 16'h0000);
    rchk(12'h230, 16'h0000);
    rchk(urs_pkg::ADDR_INTSTAT, 16'h0000);
    wreg(urs_pkg::ADDR_MODE, 16'hffff);
    rchk(urs_pkg::ADDR_MODE, 16'h8006);
    wreg(urs_pkg::ADDR_STATUS, 16'hffff);
    rchk(urs_pkg::ADDR_STATUS, 16'h01f0);
    wreg(urs_pkg::ADDR_STATUS, 16'h0000);
    wreg(urs_pkg::ADDR_BAUD, 16'hffff);
    rchk(urs_pkg::ADDR_BAUD, 16'hffff);
    wreg(urs_pkg::ADDR_BAUD, 16'h0000);
    wreg(urs_pkg::ADDR_TXDATA, 16'h01a5);
    #1;
    chk("tx data", 16'h01a5, {7'h00, tx_data});
    chk("tx load", 16'h0001, {15'h0000, tx_load});
    rchk(urs_pkg::ADDR_TXDATA, 16'h0000);
    wreg(urs_pkg::ADDR_MODE, 16'h8000);
    fork
      snd(9'h05a, 1'b0, 1'b0, 1'b1);
      begin
        repeat (40) @(posedge mclk);
        rchk(urs_pkg::ADDR_STATUS, 16'h0100);
      end
    join
    rchk(urs_pkg::ADDR_STATUS, 16'h0111);
    rchk(urs_pkg::ADDR_RXDATA, 16'h005a);
    rchk(urs_pkg::ADDR_STATUS, 16'h0110);
    // Even parity: bad parity on the first character, low stop on the second
    wreg(urs_pkg::ADDR_MODE, 16'h8002);
    snd(9'h033, 1'b1, 1'b1, 1'b1);
    snd(9'h044, 1'b1, 1'b0, 1'b0);
    rchk(urs_pkg::ADDR_STATUS, 16'h0119);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0033);
    rchk(urs_pkg::ADDR_STATUS, 16'h0115);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0044);
    rchk(urs_pkg::ADDR_STATUS, 16'h0110);
    wreg(urs_pkg::ADDR_MODE, 16'h8000);
    wreg(urs_pkg::ADDR_INTSTAT, 16'h000f);
    for (int i = 0; i < 4; i++) begin
      snd(9'h010 + 9'(i), 1'b0, 1'b0, 1'b1);
    end
    rchk(urs_pkg::ADDR_STATUS, 16'h0111);
    snd(9'h014, 1'b0, 1'b0, 1'b1);
    rchk(urs_pkg::ADDR_STATUS, 16'h0113);
    rchk(urs_pkg::ADDR_INTSTAT, 16'h0003);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wreg(urs_pkg::ADDR_INTMASK, 16'h000f);
    #1;
    chk("irq open", 16'h0001, {15'h0000, irq});
    rchk(urs_pkg::ADDR_RXDATA, 16'h0010);
    rchk(urs_pkg::ADDR_STATUS, 16'h0113);
    wreg(urs_pkg::ADDR_STATUS, 16'h0000);
    rchk(urs_pkg::ADDR_STATUS, 16'h0110);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0000);
    wreg(urs_pkg::ADDR_INTSTAT, 16'h000f);
    rchk(urs_pkg::ADDR_INTSTAT, 16'h0000);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    // Odd parity with a bad parity bit, then nine-bit address detect with the full-level event selected but not raised
    wreg(urs_pkg::ADDR_MODE, 16'h8004);
    snd(9'h033, 1'b1, 1'b0, 1'b1);
    rchk(urs_pkg::ADDR_STATUS, 16'h0119);
    rchk(urs_pkg::ADDR_INTSTAT, 16'h0009);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0033);
    wreg(urs_pkg::ADDR_INTSTAT, 16'h000f);
    wreg(urs_pkg::ADDR_MODE, 16'h8006);
    wreg(urs_pkg::ADDR_STATUS, 16'h00e0);
    lm.send(9'h0aa, 9, 1'b0, 1'b0, 1'b1);
    lm.send(9'h155, 9, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    rchk(urs_pkg::ADDR_STATUS, 16'h01f1);
    rchk(urs_pkg::ADDR_INTSTAT, 16'h0000);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0155);
    wreg(urs_pkg::ADDR_STATUS, 16'h0000);
    // Second reset in mid-run must restore the same values
    wreg(urs_pkg::ADDR_BAUD, 16'h0005);
    snd(9'h077, 1'b0, 1'b0, 1'b1);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rchk(urs_pkg::ADDR_STATUS, 16'h0110);
    rchk(urs_pkg::ADDR_MODE, 16'h0000);
    rchk(urs_pkg::ADDR_BAUD, 16'h0000);
    rchk(urs_pkg::ADDR_RXDATA, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
